// >>> hdl/aai_consts.svh
/* Named constants of the appliance alarm indicator: clock, timing,
   alarm codes, display glyphs and history depth.
   Assumes inclusion by bare name from files under hdl/. */
`ifndef AAI_CONSTS_SVH
`define AAI_CONSTS_SVH

// Clock and base tick (1 ms)
`define AAI_CLK_HZ        32'h0262_5A00
`define AAI_HZ_PER_MHZ    32'h000F_4240
`define AAI_NS_PER_US     32'h0000_03E8
`define AAI_TICK_NS       32'h000F_4240
`define AAI_TICK_CYC      ((`AAI_CLK_HZ / `AAI_HZ_PER_MHZ) * \
                           `AAI_TICK_NS / `AAI_NS_PER_US)

// Times in ms ticks, except the beep count and the gap in half-second steps
`define AAI_HALF_MS       19'h0_01F4
`define AAI_BEEP_PER_MS   19'h0_4E20
`define AAI_BUZZ_MS       19'h4_93E0
`define AAI_COMBO_MS      19'h0_07D0
`define AAI_POWERON_MS    19'h0_2710
`define AAI_BEEP_ON_MS    8'h64
`define AAI_BEEP_PITCH_MS 8'hC8
`define AAI_BEEPS         2'h3
`define AAI_GAP_HALVES    5'h02

// Alarm families and full codes
`define AAI_FAM_FILL      4'h1
`define AAI_FAM_DRAIN     4'h2
`define AAI_FAM_LOCK      4'h4
`define AAI_FAM_CFG       4'h9
`define AAI_FAM_MAINS     4'hB
`define AAI_CODE_FILL     8'h10
`define AAI_CODE_DRAIN    8'h20
`define AAI_CODE_LOCK     8'h40
`define AAI_CODE_COMM     8'h91
`define AAI_CODE_CFG2     8'h92
`define AAI_CODE_CFG3     8'h93
`define AAI_CODE_CFG4     8'h94
`define AAI_CODE_LEAK     8'hF0
`define AAI_CODE_MAINS    8'hB0
`define AAI_CODE_NONE     8'h00

// Digit glyphs: 0..F as hex value, plus letter H
`define AAI_GLYPH_E       5'h0E
`define AAI_GLYPH_H       5'h10
`define AAI_GLYPH_ZERO    5'h00

// History
`define AAI_HIST_DEPTH    3
`define AAI_HIST_OLDEST   2'h2
`define AAI_HIST_NEWEST   2'h0

`endif

// >>> hdl/aai_pkg.sv
/* Types shared by the alarm indicator modules.
   Assumes aai_consts.svh for all numeric values. */
package aai_pkg;

	typedef struct packed {
		logic [3:0] fam;
		logic [3:0] num;
	} aai_code_s;

	typedef enum logic [3:0] {
		AAI_C_OTHER = 4'h0,
		AAI_C_FILL  = 4'h1,
		AAI_C_DRAIN = 4'h2,
		AAI_C_LOCK  = 4'h3,
		AAI_C_COMM  = 4'h4,
		AAI_C_CFG2  = 4'h5,
		AAI_C_CFG3  = 4'h6,
		AAI_C_CFG4  = 4'h7,
		AAI_C_LEAK  = 4'h8,
		AAI_C_MAINS = 4'h9
	} aai_cause_e;

	typedef enum logic [4:0] {
		SEQ_IDLE = 5'h01,
		SEQ_RED  = 5'h02,
		SEQ_GAP1 = 5'h04,
		SEQ_YEL  = 5'h08,
		SEQ_GAP2 = 5'h10
	} aai_seq_e;

	typedef logic [18:0] aai_ms_t;
	typedef logic [4:0] aai_glyph_t;
	typedef aai_glyph_t [2:0] aai_digits_t;

endpackage

// >>> hdl/aai_link_if.sv
/* Carrier between the indicator core, its time base and its history.
   Assumes all parties share one clock. */
`timescale 1ns/1ps
`default_nettype none
interface aai_link_if;
	import aai_pkg::*;
	logic      ms_tick;
	logic      half_tick;
	logic      phase;
	logic      push;
	aai_code_s push_code;
	logic      clear;
	logic [1:0] rd_idx;
	aai_code_s rd_code;

	modport tbase (output ms_tick, half_tick, phase);
	modport hist (input push, push_code, clear, rd_idx, output rd_code);
	modport core (input ms_tick, half_tick, phase, rd_code,
		output push, push_code, clear, rd_idx);
endinterface
`default_nettype wire

// >>> hdl/aai_timebase.sv
/* Time base: 1 ms tick and a 0.5 s on / 0.5 s off blink phase.
   Assumes a synchronous reset and a clock enable from the core. */
`timescale 1ns/1ps
`default_nettype none
`include "aai_consts.svh"
module aai_timebase #(
	parameter int unsigned P_TICK_CYCLES = `AAI_TICK_CYC
) (
	// Clock and control
	input  wire logic i_clock,
	input  wire logic i_srst,
	input  wire logic i_ce,
	// Tick outputs
	aai_link_if.tbase lnk
);
	import aai_pkg::*;

	typedef struct packed {
		logic [31:0] div;
		aai_ms_t     ms;
		logic        tick;
		logic        half;
		logic        phase;
	} aai_tb_s;

	aai_tb_s st;
	aai_tb_s next_st;

	always_comb begin
		next_st = st;
		next_st.tick = 1'h0;
		next_st.half = 1'h0;
		if (st.div == P_TICK_CYCLES - 1) begin
			next_st.div = 32'h0000_0000;
			next_st.tick = 1'h1;
			if (st.ms == `AAI_HALF_MS - 19'h0_0001) begin
				next_st.ms = 19'h0_0000;
				next_st.half = 1'h1;
				next_st.phase = ~st.phase;
			end else begin
				next_st.ms = st.ms + 19'h0_0001;
			end
		end else begin
			next_st.div = st.div + 32'h0000_0001;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			st <= '0;
		end else if (i_ce) begin
			st <= next_st;
		end
	end

	assign lnk.ms_tick = st.tick & i_ce;
	assign lnk.half_tick = st.half & i_ce;
	assign lnk.phase = st.phase;
endmodule // aai_timebase
`default_nettype wire

// >>> hdl/aai_history.sv
/* Alarm history: the three newest codes, newest at index 0.
   Assumes push and clear are single-cycle strobes from the core. */
`timescale 1ns/1ps
`default_nettype none
`include "aai_consts.svh"
module aai_history (
	// Clock and control
	input  wire logic i_clock,
	input  wire logic i_srst,
	input  wire logic i_ce,
	// History access
	aai_link_if.hist  lnk
);
	import aai_pkg::*;

	typedef struct packed {
		aai_code_s [`AAI_HIST_DEPTH-1:0] ent;
	} aai_hist_s;

	aai_hist_s st;
	aai_hist_s next_st;

	always_comb begin
		next_st = st;
		if (lnk.clear) begin
			next_st.ent = '0;
		end
		// A push in the clearing cycle still lands
		if (lnk.push) begin
			for (int i = `AAI_HIST_DEPTH - 1; i > 0; i--) begin
				next_st.ent[i] = next_st.ent[i-1];
			end
			next_st.ent[0] = lnk.push_code;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			st <= '0;
		end else if (i_ce) begin
			st <= next_st;
		end
	end

	assign lnk.rd_code = (lnk.rd_idx > `AAI_HIST_OLDEST) ?
		st.ent[`AAI_HIST_OLDEST] : st.ent[lnk.rd_idx];
endmodule // aai_history
`default_nettype wire

// >>> hdl/aai_alarm_indicator.sv
/* Alarm and warning indication core: LEDs, cycle-time digits, buzzer
   beep requests, standby inhibit and last-alarm browsing.
   Assumes inputs synchronous to i_clock; press inputs are one-cycle
   pulses; the buzzer tone generator and segment drivers sit outside. */
`timescale 1ns/1ps
`default_nettype none
`include "aai_consts.svh"
module aai_alarm_indicator #(
	parameter int unsigned P_TICK_CYCLES = `AAI_TICK_CYC
) (
	// Clock, reset, enable
	input  wire logic                 i_clock,
	input  wire logic                 i_srst,
	input  wire logic                 i_ce,
	// Fault events from main control
	input  wire logic                 i_fault_new,
	input  wire aai_pkg::aai_cause_e  i_fault_cause,
	input  wire aai_pkg::aai_code_s   i_raw_code,
	input  wire logic                 i_fault_active,
	input  wire logic                 i_alarm_enable,
	// Machine state
	input  wire logic                 i_display_fitted,
	input  wire logic                 i_diag_mode,
	input  wire logic                 i_paused,
	input  wire logic                 i_run_led,
	// Buttons
	input  wire logic                 i_start_press,
	input  wire logic                 i_left_press,
	input  wire logic                 i_right_press,
	input  wire logic                 i_any_press,
	input  wire logic                 i_combo_held,
	input  wire logic                 i_sel_last_alarm,
	// Indicators
	output logic                      o_red_led,
	output logic                      o_yellow_led,
	output logic                      o_status_blink,
	output aai_pkg::aai_digits_t      o_cycle_time_digits,
	output logic                      o_digits_on,
	output logic                      o_beep,
	output logic                      o_standby_inhibit,
	output logic                      o_cycle_restart
);
	import aai_pkg::*;

	////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		aai_code_s   code;
		logic        warn;
		logic        buzz_on;
		aai_ms_t     buzz_ms;
		aai_ms_t     per_ms;
		logic [7:0]  pitch;
		logic [1:0]  nbeep;
		aai_seq_e    seq;
		logic [4:0]  halves;
		aai_ms_t     up_ms;
		aai_ms_t     combo_ms;
		logic        combo_q;
		logic        view;
		logic        view_full;
		logic [1:0]  vidx;
		logic        erased;
		logic        red;
		logic        yel;
		logic        stat;
		aai_digits_t dig;
		logic        dig_on;
		logic        beep;
		logic        inhibit;
		logic        restart;
	} aai_core_s;

	aai_core_s st;
	aai_core_s next_st;

	aai_link_if lnk ();

	aai_timebase #(
		.P_TICK_CYCLES (P_TICK_CYCLES)
	) u_timebase (
		.i_clock (i_clock),
		.i_srst  (i_srst),
		.i_ce    (i_ce),
		.lnk     (lnk.tbase)
	);

	aai_history u_history (
		.i_clock (i_clock),
		.i_srst  (i_srst),
		.i_ce    (i_ce),
		.lnk     (lnk.hist)
	);

	////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic aai_code_s map_cause(input aai_cause_e c,
		input aai_code_s raw);
		aai_code_s r;
		r = raw;
		case (c)
			AAI_C_FILL:  r = `AAI_CODE_FILL;
			AAI_C_DRAIN: r = `AAI_CODE_DRAIN;
			AAI_C_LOCK:  r = `AAI_CODE_LOCK;
			AAI_C_COMM:  r = `AAI_CODE_COMM;
			AAI_C_CFG2:  r = `AAI_CODE_CFG2;
			AAI_C_CFG3:  r = `AAI_CODE_CFG3;
			AAI_C_CFG4:  r = `AAI_CODE_CFG4;
			AAI_C_LEAK:  r = `AAI_CODE_LEAK;
			AAI_C_MAINS: r = `AAI_CODE_MAINS;
			default:     r = raw;
		endcase
		return r;
	endfunction

	// Families shown with full code whatever the configuration says
	function automatic logic full_code(input logic [3:0] f);
		return (f == `AAI_FAM_CFG) || (f == `AAI_FAM_MAINS);
	endfunction

	function automatic logic fixable(input logic [3:0] f);
		return (f == `AAI_FAM_FILL) || (f == `AAI_FAM_DRAIN) ||
			(f == `AAI_FAM_LOCK);
	endfunction

	function automatic aai_glyph_t glyph(input logic [3:0] n);
		return (n == `AAI_FAM_MAINS) ? `AAI_GLYPH_H : {1'h0, n};
	endfunction

	function automatic aai_digits_t draw(input aai_code_s c);
		return {`AAI_GLYPH_E, glyph(c.fam), glyph(c.num)};
	endfunction

	////////////////////////////////////////////////////////////////////
	// Next state

	aai_code_s mapped;
	logic      shown_new;
	logic      entry_seq;
	logic      combo_rise;
	logic      seq_on;
	logic [4:0] seq_len;
	aai_code_s shown;

	always_comb begin
		next_st = st;
		next_st.restart = 1'h0;
		mapped = map_cause(i_fault_cause, i_raw_code);
		shown_new = i_fault_new && (i_diag_mode || i_alarm_enable ||
			full_code(mapped.fam));
		entry_seq = !i_display_fitted &&
			(i_diag_mode || full_code(mapped.fam));
		combo_rise = i_combo_held && !st.combo_q;
		next_st.combo_q = i_combo_held;

		// Alarm raise wins over a clearing press in the same cycle
		if (shown_new) begin
			next_st.code = mapped;
			next_st.warn = 1'h1;
			next_st.erased = 1'h0;
			next_st.buzz_on = (mapped.fam != `AAI_FAM_MAINS);
			next_st.buzz_ms = 19'h0_0000;
			next_st.per_ms = 19'h0_0000;
			next_st.pitch = 8'h00;
			next_st.nbeep = 2'h0;
			next_st.seq = entry_seq ? SEQ_RED : SEQ_IDLE;
			next_st.halves = 5'h00;
		end else if (st.warn && i_start_press && !i_fault_active) begin
			next_st.warn = 1'h0;
			next_st.buzz_on = 1'h0;
			next_st.seq = SEQ_IDLE;
			next_st.restart = i_display_fitted;
		end

		// Buzzer: 3 short beeps each period, for a bounded time
		// A raise restarts the timers, so the old step is dropped
		if (st.buzz_on && lnk.ms_tick && !shown_new) begin
			next_st.buzz_ms = st.buzz_ms + 19'h0_0001;
			if (st.buzz_ms == `AAI_BUZZ_MS - 19'h0_0001) begin
				next_st.buzz_on = 1'h0;
			end
			if (st.per_ms == `AAI_BEEP_PER_MS - 19'h0_0001) begin
				next_st.per_ms = 19'h0_0000;
				next_st.pitch = 8'h00;
				next_st.nbeep = 2'h0;
			end else begin
				next_st.per_ms = st.per_ms + 19'h0_0001;
				if (st.pitch == `AAI_BEEP_PITCH_MS - 8'h01) begin
					next_st.pitch = 8'h00;
					if (st.nbeep != `AAI_BEEPS) begin
						next_st.nbeep = st.nbeep + 2'h1;
					end
				end else begin
					next_st.pitch = st.pitch + 8'h01;
				end
			end
		end

		// Entry-level code blinking: red count, gap, yellow count, gap
		seq_len = (st.seq == SEQ_RED) ? {st.code.fam, 1'h0} :
			(st.seq == SEQ_YEL) ? {st.code.num, 1'h0} :
			`AAI_GAP_HALVES;
		if (lnk.half_tick && st.seq != SEQ_IDLE &&
			!shown_new) begin
			next_st.halves = st.halves + 5'h01;
			if (st.halves + 5'h01 >= seq_len) begin
				next_st.halves = 5'h00;
				case (st.seq)
					SEQ_RED:  next_st.seq = SEQ_GAP1;
					SEQ_GAP1: next_st.seq = SEQ_YEL;
					SEQ_YEL:  next_st.seq = SEQ_GAP2;
					SEQ_GAP2: next_st.seq = SEQ_RED;
					default:  next_st.seq = SEQ_IDLE;
				endcase
			end
		end

		// Power-on age and combination hold time
		if (lnk.ms_tick && st.up_ms != `AAI_POWERON_MS) begin
			next_st.up_ms = st.up_ms + 19'h0_0001;
		end
		if (!i_combo_held) begin
			next_st.combo_ms = 19'h0_0000;
		end else if (lnk.ms_tick && st.combo_ms != `AAI_COMBO_MS) begin
			next_st.combo_ms = st.combo_ms + 19'h0_0001;
		end

		// Last-alarm viewing
		if (i_diag_mode && i_sel_last_alarm) begin
			if (!st.view || !st.view_full) begin
				next_st.vidx = `AAI_HIST_NEWEST;
			end
			next_st.view = 1'h1;
			next_st.view_full = 1'h1;
			// Raise wins: the pushed code survives the clear
			if (combo_rise && !shown_new) begin
				next_st.erased = 1'h1;
				next_st.warn = 1'h0;
				next_st.seq = SEQ_IDLE;
				next_st.buzz_on = 1'h0;
			end else if (i_right_press) begin
				next_st.vidx = `AAI_HIST_NEWEST;
			end else if (i_left_press &&
				st.vidx != `AAI_HIST_OLDEST) begin
				next_st.vidx = st.vidx + 2'h1;
			end
		end else if (st.view && st.view_full) begin
			next_st.view = 1'h0;
		end else if (st.view) begin
			if (i_any_press) begin
				next_st.view = 1'h0;
			end
		end else if (!i_diag_mode && lnk.ms_tick &&
			st.up_ms == `AAI_POWERON_MS &&
			st.combo_ms == `AAI_COMBO_MS - 19'h0_0001) begin
			next_st.view = 1'h1;
			next_st.view_full = 1'h0;
			next_st.vidx = `AAI_HIST_NEWEST;
		end

		// Outputs
		seq_on = st.seq != SEQ_IDLE;
		next_st.beep = st.buzz_on && st.nbeep != `AAI_BEEPS &&
			st.pitch < `AAI_BEEP_ON_MS;
		next_st.inhibit = st.warn;
		next_st.stat = st.warn && !seq_on && fixable(st.code.fam) &&
			lnk.phase;
		if (!i_display_fitted && seq_on) begin
			next_st.red = st.seq == SEQ_RED && !st.halves[0];
			next_st.yel = st.seq == SEQ_YEL && !st.halves[0];
		end else if (!i_display_fitted) begin
			next_st.red = st.warn && lnk.phase;
			next_st.yel = st.warn ? 1'h0 : i_run_led;
		end else begin
			next_st.red = st.warn && lnk.phase;
			next_st.yel = (st.warn && i_paused) ? lnk.phase :
				i_run_led;
		end

		shown = st.code;
		if (!(i_diag_mode || full_code(st.code.fam))) begin
			shown.num = 4'h0;
		end
		next_st.dig_on = i_display_fitted && (st.view || st.warn);
		if (st.view && st.erased) begin
			next_st.dig = {`AAI_GLYPH_E, `AAI_GLYPH_ZERO,
				`AAI_GLYPH_ZERO};
		end else if (st.view) begin
			next_st.dig = draw(lnk.rd_code);
		end else begin
			next_st.dig = draw(shown);
		end
	end

	assign lnk.push = i_fault_new;
	assign lnk.push_code = mapped;
	assign lnk.clear = i_diag_mode && i_sel_last_alarm &&
		combo_rise;
	assign lnk.rd_idx = st.vidx;

	////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			st <= '0;
			st.seq <= SEQ_IDLE;
		end else if (i_ce) begin
			st <= next_st;
		end
	end

	assign o_red_led = st.red;
	assign o_yellow_led = st.yel;
	assign o_status_blink = st.stat;
	assign o_cycle_time_digits = st.dig;
	assign o_digits_on = st.dig_on;
	assign o_beep = st.beep;
	assign o_standby_inhibit = st.inhibit;
	assign o_cycle_restart = st.restart;
endmodule // aai_alarm_indicator
`default_nettype wire

// >>> tb/aai_alarm_indicator_properties.sv
/* Checker for the alarm indicator top module ports.
   Assumes one clock, synchronous reset; bound at the foot. */
`timescale 1ns/1ps
`default_nettype none
`include "aai_consts.svh"
module aai_alarm_indicator_properties #(
	parameter int unsigned P_TICK_CYCLES = 4
) (
	// Clock and reset
	input wire logic                i_clock,
	input wire logic                i_srst,
	// Observed inputs
	input wire logic                i_fault_new,
	input wire aai_pkg::aai_cause_e i_fault_cause,
	input wire logic                i_fault_active,
	input wire logic                i_alarm_enable,
	input wire logic                i_display_fitted,
	input wire logic                i_diag_mode,
	input wire logic                i_start_press,
	input wire logic                i_sel_last_alarm,
	// Observed outputs
	input wire logic                o_red_led,
	input wire logic                o_yellow_led,
	input wire aai_pkg::aai_digits_t o_cycle_time_digits,
	input wire logic                o_digits_on,
	input wire logic                o_beep,
	input wire logic                o_standby_inhibit,
	input wire logic                o_cycle_restart
);
	import aai_pkg::*;
	localparam int unsigned HALF_CYC = 500 * P_TICK_CYCLES;
	logic        red_q;
	logic [31:0] red_cnt;
	logic [31:0] red_low;

	// Length of the current red level in cycles
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			red_q   <= 1'b0;
			red_cnt <= 32'h0000_0000;
			red_low <= 32'h0000_0000;
		end else begin
			red_q   <= o_red_led;
			// Low time before the current blink, taken at its rise
			if (o_red_led && !red_q) begin
				red_low <= red_cnt;
			end
			red_cnt <= (o_red_led != red_q) ? 32'h0000_0001 :
				red_cnt + 32'h0000_0001;
		end
	end

	default clocking @(posedge i_clock); endclocking
	default disable iff (i_srst);

	////////////////////////////////////////////////////////////////////
	chk_reset_quiet: assert property ($fell(i_srst) |-> !o_red_led &&
		!o_yellow_led && !o_beep && !o_digits_on && !o_standby_inhibit)
		else $error("outputs not quiet after reset");
	chk_blink_half: assert property ($fell(o_red_led) && i_fault_active
		&& red_low == HALF_CYC |-> red_cnt == HALF_CYC)
		else $error("red on time wrong");
	chk_entry_dark: assert property (!i_display_fitted && o_red_led
		|-> !o_yellow_led) else $error("yellow lit with red");
	chk_digits_e: assert property (o_digits_on
		|-> o_cycle_time_digits[2] == `AAI_GLYPH_E)
		else $error("left digit not E");
	chk_mains_quiet: assert property (o_digits_on &&
		o_cycle_time_digits[1] == `AAI_GLYPH_H |-> !o_beep)
		else $error("beep for mains family");
	chk_standby_cause: assert property ($rose(o_standby_inhibit)
		|-> $past(i_fault_new, 2)) else $error("inhibit without fault");
	chk_restart_pulse: assert property (o_cycle_restart
		|-> i_display_fitted ##1 !o_cycle_restart)
		else $error("restart pulse wrong");
	chk_clear_start: assert property (i_start_press && !i_fault_active
		&& !i_fault_new && !i_diag_mode && !i_sel_last_alarm && o_digits_on
		|-> ##[1:3] !o_digits_on) else $error("warning not cleared");
	chk_start_refused: assert property (i_start_press && i_fault_active
		&& o_digits_on |=> o_digits_on [*3]) else $error("warning dropped");
	chk_fill_code: assert property (i_fault_new &&
		i_fault_cause == AAI_C_FILL && i_display_fitted &&
		(i_alarm_enable || i_diag_mode) && !i_sel_last_alarm |-> ##2
		o_cycle_time_digits == {`AAI_GLYPH_E, 5'h01, `AAI_GLYPH_ZERO})
		else $error("fill code digits wrong");

	cover property ($rose(o_cycle_restart));
	cover property ($fell(o_red_led) && i_fault_active);
	cover property (o_digits_on && o_cycle_time_digits[1] == `AAI_GLYPH_H);
endmodule // aai_alarm_indicator_properties

bind aai_alarm_indicator aai_alarm_indicator_properties #(
	.P_TICK_CYCLES(P_TICK_CYCLES)
) u_props (
	.i_clock(i_clock), .i_srst(i_srst), .i_fault_new(i_fault_new),
	.i_fault_cause(i_fault_cause), .i_fault_active(i_fault_active),
	.i_alarm_enable(i_alarm_enable), .i_display_fitted(i_display_fitted),
	.i_diag_mode(i_diag_mode), .i_start_press(i_start_press),
	.i_sel_last_alarm(i_sel_last_alarm), .o_red_led(o_red_led),
	.o_yellow_led(o_yellow_led), .o_cycle_time_digits(o_cycle_time_digits),
	.o_digits_on(o_digits_on), .o_beep(o_beep),
	.o_standby_inhibit(o_standby_inhibit), .o_cycle_restart(o_cycle_restart)
);
`default_nettype wire

// >>> tb/aai_panel_model.sv
/* Front panel push buttons: one-cycle press pulses.
   Assumes presses are launched at the falling clock edge. */
`timescale 1ns/1ps
`default_nettype none
module aai_panel_model (
	// Clock
	input  wire logic i_clock,
	// Press pulses
	output var logic  o_start_press,
	output var logic  o_left_press,
	output var logic  o_right_press,
	output var logic  o_any_press
);
	initial {o_start_press, o_left_press, o_right_press, o_any_press} = 4'h0;

	// Kind 0 start, 1 left, 2 right
	task automatic press(input int kind);
		@(negedge i_clock);
		o_start_press = (kind == 0);
		o_left_press  = (kind == 1);
		o_right_press = (kind == 2);
		o_any_press   = 1'b1;
		@(negedge i_clock);
		{o_start_press, o_left_press, o_right_press, o_any_press} = 4'h0;
	endtask
endmodule // aai_panel_model
`default_nettype wire

// >>> tb/aai_alarm_indicator_test.sv
/* Self-checking bench of the alarm indicator.
   Assumes a shortened tick of 4 cycles per ms. */
`timescale 1ns/1ps
`default_nettype none
`include "aai_consts.svh"
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin \
	fails++; $display("[FAIL] %0t %s", $time, m); end end
module aai_alarm_indicator_test;
	import aai_pkg::*;
	localparam int TICK = 4;
	localparam int HALF = 500 * TICK;
	logic clk = 0, srst = 1, fnew = 0, fact = 0, en = 1, disp = 1;
	logic diag = 0, paused = 0, run_led = 0, combo = 0, sel = 0;
	logic red, yel, stat, don, beep, inh, rst_p, ybad, sbad;
	wire logic start_p, left_p, right_p, any_p;
	aai_cause_e  cause = AAI_C_OTHER;
	aai_code_s   raw = '0, c;
	aai_code_s   h [3];
	aai_digits_t digs;
	int fails = 0, check_count = 0, seed = 11497, restarts = 0, r0, n, r, y;
	logic [7:0] codes [10] = '{8'h00, 8'h10, 8'h20, 8'h40, 8'h91, 8'h92,
		8'h93, 8'h94, 8'hF0, 8'hB0};

	aai_alarm_indicator #(.P_TICK_CYCLES(TICK)) uut (
		.i_clock(clk), .i_srst(srst), .i_ce(1'b1), .i_fault_new(fnew),
		.i_fault_cause(cause), .i_raw_code(raw), .i_fault_active(fact),
		.i_alarm_enable(en), .i_display_fitted(disp), .i_diag_mode(diag),
		.i_paused(paused), .i_run_led(run_led), .i_start_press(start_p),
		.i_left_press(left_p), .i_right_press(right_p), .i_any_press(any_p),
		.i_combo_held(combo), .i_sel_last_alarm(sel), .o_red_led(red),
		.o_yellow_led(yel), .o_status_blink(stat),
		.o_cycle_time_digits(digs), .o_digits_on(don), .o_beep(beep),
		.o_standby_inhibit(inh), .o_cycle_restart(rst_p));
	aai_panel_model panel (.i_clock(clk), .o_start_press(start_p),
		.o_left_press(left_p), .o_right_press(right_p), .o_any_press(any_p));

	initial forever #12.5 clk = ~clk;
	always @(posedge clk) if (rst_p === 1'b1) restarts++;

	////////////////////////////////////////////////////////////////////
	function automatic aai_glyph_t gl(input logic [3:0] v);
		return (v == 4'hB) ? `AAI_GLYPH_H : {1'b0, v};
	endfunction
	function automatic aai_digits_t full(input aai_code_s k);
		return {`AAI_GLYPH_E, gl(k.fam), gl(k.num)};
	endfunction
	function automatic aai_digits_t user(input aai_code_s k);
		if (k.fam == 4'h9 || k.fam == 4'hB) return full(k);
		return {`AAI_GLYPH_E, gl(k.fam), `AAI_GLYPH_ZERO};
	endfunction
	function automatic aai_code_s rnd();
		return {4'(1 + ($random(seed) & 7)), 4'($random(seed))};
	endfunction

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic raise(input aai_cause_e cs, input aai_code_s rc);
		@(negedge clk);
		fnew = 1;
		cause = cs;
		raw = rc;
		fact = 1;
		@(negedge clk);
		fnew = 0;
		cyc(2);
	endtask
	task automatic clear();
		@(negedge clk);
		fact = 0;
		panel.press(0);
		cyc(3);
	endtask
	// High time of red (0) or yellow (1), from its next rise
	task automatic hi_len(input bit w, output int len);
		len = 0;
		for (int k = 0; k < 5000 && (w ? yel : red) === 1'b1; k++) cyc(1);
		for (int k = 0; k < 5000 && (w ? yel : red) !== 1'b1; k++) cyc(1);
		while ((w ? yel : red) === 1'b1 && len < 5000) begin
			len++;
			ybad |= !w && yel !== 1'b0;
			sbad |= stat !== red;
			cyc(1);
		end
	endtask
	// Counts of one full red run and the yellow run after it
	task automatic count_seq(output int rc, output int yc);
		int st;
		logic pr, py;
		st = 0; rc = 0; yc = 0; pr = red; py = yel;
		for (int k = 0; k < 60000 && st < 4; k++) begin
			cyc(1);
			if (red && !pr) case (st)
				1: begin rc = 1; st = 2; end
				2: rc++;
				3: st = 4;
				default: ;
			endcase
			if (yel && !py) case (st)
				0: st = 1;
				2: begin yc = 1; st = 3; end
				3: yc++;
				default: ;
			endcase
			pr = red;
			py = yel;
		end
	endtask

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge clk);
		fails++;
		$display("[FAIL] %0t watchdog expired", $time);
		final_report();
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		ybad = 0;
		sbad = 0;
		repeat (6) @(posedge clk);
		@(negedge clk) srst = 0;
		// Every cause on the digits, cause 0 with a random raw code
		for (int i = 0; i < 10; i++) begin
			c = (i == 0) ? rnd() : codes[i];
			en = (c.fam == 4'h9 || c.fam == 4'hB) ? 1'($random(seed)) : 1'b1;
			raise(aai_cause_e'(i), c);
			`CHK(don, 1'b1, "alarm not shown")
			`CHK(digs, user(c), "code digits")
			`CHK(beep, c.fam != 4'hB, "beep request")
			`CHK(inh, 1'b1, "standby not inhibited")
			r0 = restarts;
			panel.press(0);
			cyc(3);
			`CHK(don, 1'b1, "start press with fault cleared code")
			clear();
			`CHK(don, 1'b0, "code still shown")
			`CHK(beep, 1'b0, "beep still on")
			`CHK(restarts, r0 + 1, "restart pulses")
		end
		en = 0;
		raise(AAI_C_FILL, '0);
		`CHK(don, 1'b0, "disabled alarm shown")
		`CHK(inh, 1'b0, "inhibit for hidden alarm")
		clear();
		diag = 1;
		raise(AAI_C_OTHER, 8'hB3);
		`CHK(digs, full(8'hB3), "diag code")
		`CHK(beep, 1'b0, "beep for mains family")
		clear();
		// History browsing and clearing
		for (int k = 0; k < 3; k++) begin
			h[k] = rnd();
			@(negedge clk);
			fnew = 1;
			raw = h[k];
		end
		@(negedge clk) fnew = 0;
		@(negedge clk) sel = 1;
		cyc(3);
		`CHK(digs, full(h[2]), "newest first")
		for (int k = 1; k < 4; k++) begin
			panel.press(1);
			cyc(3);
			`CHK(digs, full(h[k > 2 ? 0 : 2 - k]), "older step")
		end
		panel.press(2);
		cyc(3);
		`CHK(digs, full(h[2]), "back to newest")
		@(negedge clk) combo = 1;
		cyc(3);
		`CHK(digs, {`AAI_GLYPH_E, 10'h000}, "cleared code")
		`CHK(beep, 1'b0, "beep after clear")
		@(negedge clk);
		{combo, sel, diag, disp, en} = 5'h01;
		run_led = 1'($random(seed));
		// Entry level red blink
		raise(AAI_C_FILL, '0);
		hi_len(0, n);
		`CHK(n, HALF, "red on time")
		`CHK(ybad, 1'b0, "yellow lit")
		`CHK(sbad, 1'b0, "status out of step")
		clear();
		`CHK(red, 1'b0, "red still lit")
		`CHK(yel, run_led, "yellow not restored")
		`CHK(stat, 1'b0, "status still blinking")
		// Display level pause blink
		@(negedge clk) {disp, paused} = 2'h3;
		raise(AAI_C_FILL, '0);
		hi_len(1, n);
		`CHK(n, HALF, "yellow on time")
		clear();
		// Diagnostic entry count sequence
		@(negedge clk) {disp, paused, diag} = 3'h1;
		raise(AAI_C_OTHER, 8'h21);
		count_seq(r, y);
		`CHK(r, 2, "red count")
		`CHK(y, 1, "yellow count")
		clear();
		final_report();
	end
endmodule // aai_alarm_indicator_test
`default_nettype wire
